// [inc/sas_map.vh]
// Constants for the store-all and skip microsequencer.
// Assumes a 16-bit datapath and a phase timer producing four phases per state.
`ifndef SAS_MAP_VH
`define SAS_MAP_VH
// *****************************
// Counter and field constants
// *****************************
`define SAS_RSC_W 4
`define SAS_RSC_ZERO 4'h0
`define SAS_RSC_END 4'h8
`define SAS_DISPLACEMENT_FIELD_TOP 8
`define SAS_SC_W 4
// *****************************
// Status word field positions
// *****************************
`define SAS_ST_FRG 15
`define SAS_ST_ZERO 14
`define SAS_ST_PLUS 13
`define SAS_ST_OVERFLOW_INDICATOR 12
`define SAS_ST_LINK 11
`define SAS_ST_PAD 7'h00
// *****************************
// Phase codes, one-hot
// *****************************
`define SAS_PH_D01 4'h1
`define SAS_PH_D02 4'h2
`define SAS_PH_D03 4'h4
`define SAS_PH_D04 4'h8
`endif

// [src/sas_phase.v]
// Phase ring: steps D01..D04, one clock enable per phase.
// Assumes a phase enable pulse from the processor timing divider.
`timescale 1ns/100ps
`include "sas_map.vh"
module sas_phase (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Timing
  input wire ph_en,
  input wire ph_hold,
  input wire ph_jump_d03,
  // Phase
  output reg [3:0] phase_q
);
  // *****************************
  // Ring advance
  // *****************************
  // Jump to D03 lets a skip land in S5 D03 directly
  always @(posedge sys_clk) begin
    if (rst) begin
      phase_q <= `SAS_PH_D01;
    end else if (ph_en && !ph_hold) begin
      if (ph_jump_d03) begin
        phase_q <= `SAS_PH_D03;
      end else begin
        phase_q <= {phase_q[2:0], phase_q[3]};
      end
    end
  end
endmodule // sas_phase

// [src/sas_seq.v]
// Microsequencer for store-all-registers and conditional skip classes.
// Assumes shared S1-S3 address steps run elsewhere; this block reproduces
// their state flow for store-all and owns S4/S5 and the skip path.
//
// Contract
// - Store-all S1-S3 same as load-all.
// - S4 D01 loads Q,R from counter register.
// - S4 D02 copies R into memory data.
// - S4 D03 increments address and counter.
// - S4 D04 latches address, loops until eight.
// - Memory start issued at end of S4 D04.
// - Count one stores index, seven last register.
// - Loop ends after count seven, counter eight.
// - S5 D02 stores status word into memory data.
// - Skip jumps when condition true, else sequential.
// - Skip S1 D02 increments P, loads Q,R, jumps.
// - Condition true adds sign-extended displacement to P.
// - Condition false keeps incremented P.
// - Overflow skips clear overflow in S5 D04; the code skips the clear when ovf_set is high in that cycle.
// - S5 D04 copies P to latch, returns to idle.
`timescale 1ns/100ps
`include "sas_map.vh"
module sas_seq (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Timing and instruction
  input wire ph_en,
  input wire start,
  input wire op_store_all,
  input wire op_skip,
  input wire op_ovf_skip,
  input wire skip_cond,
  input wire indirect,
  input wire [15:0] instr,
  input wire extra_increment_term,
  // Register file access
  input wire [15:0] reg_rd_data,
  input wire [2:0] rd_sel,
  output reg [2:0] reg_rd_sel,
  // Memory side
  input wire [15:0] mem_rd_data,
  output reg [15:0] mdr_q,
  output reg [15:0] addr_latch_q,
  output reg mem_start,
  // Flags
  input wire foreground_flag,
  input wire zero_flag,
  input wire plus_flag,
  input wire link_flag,
  input wire [3:0] shift_count,
  output reg overflow_indicator,
  input wire ovf_set,
  // Processor state
  output reg [15:0] pc_q,
  output reg [15:0] war_q,
  output reg [15:0] q_q,
  output reg [15:0] r_q,
  output reg [3:0] rsc_q,
  output wire [4:0] state,
  output wire busy
);
  // *****************************
  // States, one-hot except idle, which is all zero
  // *****************************
  localparam ST_S1 = 5'h01;
  localparam ST_S2 = 5'h02;
  localparam ST_S3 = 5'h04;
  localparam ST_S4 = 5'h08;
  localparam ST_S5 = 5'h10;
  localparam ST_IDLE = 5'h00;

  reg [4:0] st_q; // Current major state
  reg skip_q; // Instruction class latched at start
  reg ovf_q; // Overflow-testing skip variant
  reg cond_q; // Condition captured in S5 D03
  wire [3:0] phase; // Current phase
  wire d01 = phase == `SAS_PH_D01;
  wire d02 = phase == `SAS_PH_D02;
  wire d03 = phase == `SAS_PH_D03;
  wire d04 = phase == `SAS_PH_D04;
  wire idle = st_q == ST_IDLE;
  wire jump_d03 = (st_q == ST_S1) && skip_q && d02; // Skip bypasses to S5 D03
  wire [15:0] displacement_field_five = {11'h000, instr[4:0]}; // Short displacement for EA
  wire [15:0] sext_off; // sign_extended_offset
  wire [15:0] pc_inc; // P+1+extra increment

  assign sext_off = {{7{mem_rd_data[`SAS_DISPLACEMENT_FIELD_TOP]}},
                     mem_rd_data[`SAS_DISPLACEMENT_FIELD_TOP:0]};
  assign pc_inc = pc_q + 16'h0001 + {15'h0000, extra_increment_term};
  assign state = st_q;
  assign busy = !idle;

  // *****************************
  // Phase ring
  // *****************************
  sas_phase u_phase (
    .sys_clk(sys_clk),
    .rst(rst || idle),
    .ph_en(ph_en),
    .ph_hold(1'b0),
    .ph_jump_d03(jump_d03),
    .phase_q(phase)
  );

  // *****************************
  // Register read select
  // *****************************
  // Counter picks register in S4; destination elsewhere
  always @* begin
    if (st_q == ST_S4) begin
      reg_rd_sel = rsc_q[2:0];
    end else begin
      reg_rd_sel = rd_sel;
    end
  end

  // *****************************
  // Main sequencer
  // *****************************
  // State and datapath advance on phase enables only; start clear and overflow set act every clock
  always @(posedge sys_clk) begin
    if (rst) begin
      st_q <= ST_IDLE;
      skip_q <= 1'b0;
      ovf_q <= 1'b0;
      cond_q <= 1'b0;
      pc_q <= 16'h0000;
      war_q <= 16'h0000;
      q_q <= 16'h0000;
      r_q <= 16'h0000;
      mdr_q <= 16'h0000;
      addr_latch_q <= 16'h0000;
      rsc_q <= `SAS_RSC_ZERO;
      mem_start <= 1'b0;
      overflow_indicator <= 1'b0;
    end else begin
      mem_start <= 1'b0;
      if (ovf_set) begin
        overflow_indicator <= 1'b1; // Flag set from ALU
      end
      if (idle) begin
        // Wait for a decoded instruction
        if (ph_en && start && (op_store_all || op_skip)) begin
          st_q <= ST_S1;
          skip_q <= op_skip;
          ovf_q <= op_ovf_skip;
        end
      end else if (ph_en) begin
        case (st_q)
          ST_S1: begin
            if (!skip_q) begin
              rsc_q <= `SAS_RSC_ZERO;
            end
            if (d02) begin
              pc_q <= pc_inc;
              q_q <= reg_rd_data;
              r_q <= reg_rd_data;
              if (skip_q) begin
                st_q <= ST_S5;
              end
            end
            if (d03) begin
              war_q <= displacement_field_five;
            end
            if (d04) begin
              // Shared effective-address flow
              if (indirect) begin
                war_q <= war_q + r_q;
                addr_latch_q <= war_q + r_q;
                st_q <= ST_S3;
              end else begin
                war_q <= war_q + r_q;
                addr_latch_q <= war_q + r_q;
                st_q <= ST_S4;
              end
              mem_start <= 1'b1;
            end
          end
          ST_S2: begin
            if (d04) begin
              st_q <= ST_S3;
            end
          end
          ST_S3: begin
            if (d03) begin
              war_q <= mem_rd_data;
            end
            if (d04) begin
              addr_latch_q <= war_q;
              mem_start <= 1'b1;
              st_q <= ST_S4;
            end
          end
          ST_S4: begin
            if (d01) begin
              q_q <= reg_rd_data;
              r_q <= reg_rd_data;
            end
            if (d02) begin
              mdr_q <= r_q;
            end
            if (d03) begin
              war_q <= war_q + 16'h0001;
              rsc_q <= rsc_q + 4'h1;
            end
            if (d04) begin
              // Incremented address latched now; the start then writes the word to the old one
              addr_latch_q <= war_q;
              mem_start <= 1'b1;
              if (rsc_q == `SAS_RSC_END) begin
                st_q <= ST_S5;
              end
            end
          end
          ST_S5: begin
            if (d02 && !skip_q) begin
              mdr_q <= {foreground_flag, zero_flag, plus_flag,
                        overflow_indicator, link_flag, `SAS_ST_PAD,
                        shift_count};
            end
            if (d03 && skip_q) begin
              cond_q <= skip_cond;
              if (skip_cond) begin
                pc_q <= pc_q + sext_off;
              end
              // Otherwise P keeps its incremented value
            end
            if (d04) begin
              // Clear yields to a same-cycle set so an ALU overflow is not lost
              if (skip_q && ovf_q && !ovf_set) begin
                overflow_indicator <= 1'b0;
              end
              addr_latch_q <= pc_q;
              st_q <= ST_IDLE;
            end
          end
          default: begin
            st_q <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule // sas_seq

// [tb/sas_mem_model.sv]
// Main memory model on the far side of the address latch.
// Assumes each start opens a cycle at the latch; its data lands at the next start.
`timescale 1ns/100ps
module sas_mem_model (
  // Clock
  input wire sys_clk,
  // Memory side
  input wire [15:0] addr_latch_q,
  input wire [15:0] mdr_q,
  input wire mem_start,
  output wire [15:0] mem_rd_data
);
  reg [15:0] mem_q [0:255]; // Small, address wraps
  reg [15:0] pend_addr_q; // Address of the open cycle
  reg pend_q = 1'b0; // A cycle is open
  integer n;
  // Preset all words
  task fill(input [15:0] v);
    for (n = 0; n < 256; n = n + 1) mem_q[n] = v;
  endtask
  // Write half of the open cycle completes at the next start
  always @(posedge sys_clk) begin
    if (mem_start) begin
      if (pend_q) mem_q[pend_addr_q[7:0]] <= mdr_q;
      pend_addr_q <= addr_latch_q;
      pend_q <= 1'b1;
    end
  end
  // Read data follows the latch, no hold
  assign mem_rd_data = mem_q[addr_latch_q[7:0]];
endmodule // sas_mem_model

// [tb/sas_seq_properties.sv]
// Checker on the sequencer ports.
// Assumes class inputs stay up for a whole instruction.
`timescale 1ns/100ps
module sas_seq_properties (
  input wire sys_clk,
  input wire rst,
  input wire ph_en,
  input wire op_store_all,
  input wire op_ovf_skip,
  input wire ovf_set,
  input wire [15:0] mdr_q,
  input wire [15:0] addr_latch_q,
  input wire mem_start,
  input wire overflow_indicator,
  input wire [15:0] pc_q,
  input wire [15:0] war_q,
  input wire [15:0] r_q,
  input wire [3:0] rsc_q,
  input wire [4:0] state
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // Steps in S4 only, entry edge excluded
  sequence s_in_s4;
    state == 5'h08 && $past(state) == 5'h08;
  endsequence
  sequence s_off_s4;
    $fell(state[3]);
  endsequence
  sequence s_off_s5;
    $fell(state[4]);
  endsequence
  a_rsc_clear: assert property (state == 5'h01 && ph_en && op_store_all |=> rsc_q == 4'h0)
    else $error("count not cleared");
  a_rsc_step: assert property (s_in_s4 ##0 $changed(rsc_q) |-> rsc_q == $past(rsc_q) + 4'h1)
    else $error("bad count step");
  a_war_step: assert property (s_in_s4 ##0 $changed(war_q) |-> war_q == $past(war_q) + 16'h1)
    else $error("bad address step");
  a_mdr_from_r: assert property (s_in_s4 ##0 $changed(mdr_q) |-> mdr_q == r_q)
    else $error("bad data copy");
  a_loop_exit: assert property (s_off_s4 |-> rsc_q == 4'h8 && state == 5'h10)
    else $error("bad loop exit");
  a_latch_war: assert property ($rose(mem_start) && state == 5'h08 |-> addr_latch_q == war_q)
    else $error("latch not address");
  a_start_pulse: assert property (mem_start |=> !mem_start)
    else $error("start too long");
  a_pc_latch: assert property (s_off_s5 |-> addr_latch_q == pc_q && state == 5'h00)
    else $error("latch not pc");
  a_ovf_clear: assert property (s_off_s5 ##0 ($past(op_ovf_skip) && !$past(ovf_set)) |-> !overflow_indicator)
    else $error("overflow kept");
endmodule // sas_seq_properties
bind sas_seq sas_seq_properties u_chk (.*);

// [tb/tb_sas_seq.sv]
// Bench for the store-all and skip sequencer.
// Assumes a register file answering 16'h1000 plus index.
`timescale 1ns/100ps
module tb_sas_seq;
  reg sys_clk, rst, ph_en, start, op_store_all, op_skip, op_ovf_skip;
  reg skip_cond, indirect, extra_increment_term, ovf_set;
  reg foreground_flag, zero_flag, plus_flag, link_flag;
  reg [3:0] shift_count;
  reg [15:0] instr;
  reg [2:0] rd_sel;
  wire [15:0] reg_rd_data, mem_rd_data, mdr_q, addr_latch_q, pc_q, war_q, q_q, r_q;
  wire [2:0] reg_rd_sel;
  wire [3:0] rsc_q;
  wire [4:0] state;
  wire mem_start, overflow_indicator, busy;
  reg [15:0] wa[$];
  reg [15:0] wd[$];
  reg [15:0] p0;
  integer errors, num_checks, i, k;
  sas_seq dut (.*);
  sas_mem_model mem (.*);
  // Register file: word = 16'h1000 + index
  assign reg_rd_data = 16'h1000 + {13'h0000, reg_rd_sel};
  initial begin
    sys_clk = 0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Log address and data at every memory start
  always @(posedge sys_clk) begin
    if (mem_start === 1'b1 && !rst) begin
      wa.push_back(addr_latch_q);
      wd.push_back(mdr_q);
    end
  end
  task check(input [15:0] seen, input [15:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One instruction, bounded wait for idle
  task run(input sa, input sk, input ov);
    {op_store_all, op_skip, op_ovf_skip, start} = {sa, sk, ov, 1'b1};
    @(negedge sys_clk);
    start = 0;
    i = 0;
    while (busy !== 1'b0 && i < 200) begin
      @(negedge sys_clk);
      i = i + 1;
    end
    if (busy !== 1'b0) begin
      errors = errors + 1;
      print_verdict;
    end
    {op_store_all, op_skip, op_ovf_skip} = 3'h0;
    check(addr_latch_q, pc_q);
    // Let an edge pass so the next call does not reassign the class
    @(negedge sys_clk);
  endtask
  initial begin
    {rst, ph_en, start, op_store_all, op_skip, op_ovf_skip} = 6'h20;
    {skip_cond, indirect, extra_increment_term, ovf_set} = 4'h0;
    {foreground_flag, zero_flag, plus_flag, link_flag, shift_count} = 8'hb5;
    instr = 16'h0005;
    rd_sel = 3'h3;
    errors = 0;
    num_checks = 0;
    repeat (16) @(negedge sys_clk);
    rst = 0;
    ph_en = 1;
    // Store-all: eight words then status
    run(1, 0, 0);
    // First start opens the cycle at the address; data follows one start later
    check(wa[0], 16'h1008);
    for (k = 0; k < 8; k = k + 1) begin
      check(wd[k + 1], 16'h1000 + k[15:0]);
      check(wa[k + 1], 16'h1009 + k[15:0]);
      check(mem.mem_q[8 + k], 16'h1000 + k[15:0]);
    end
    check(mdr_q, 16'ha805);
    // Skip taken, negative offset
    mem.fill(16'h01f0);
    p0 = pc_q;
    skip_cond = 1;
    run(0, 1, 0);
    check(pc_q, p0 + 16'hfff1);
    check(q_q, 16'h1003);
    // Skip not taken, extra increment
    p0 = pc_q;
    skip_cond = 0;
    extra_increment_term = 1;
    run(0, 1, 0);
    check(pc_q, p0 + 16'h2);
    // Overflow kept by plain skip, cleared by overflow skip
    ovf_set = 1;
    @(negedge sys_clk);
    ovf_set = 0;
    run(0, 1, 0);
    check({15'h0000, overflow_indicator}, 16'h1);
    run(0, 1, 1);
    check({15'h0000, overflow_indicator}, 16'h0);
    print_verdict;
  end
endmodule // tb_sas_seq
